// ===== rtl/vsc_defs.svh
// constants of the serial voltage command decoder
// Operation
// - decode read commands returning data and set commands changing setpoint or power state
// - on own address a read is acknowledged then register contents returned
// - every fast or slow setpoint or power state set command addressed here with good parity is acknowledged
// - pointer command loads scratch index; data command writes the register it selects
// - parity errors never reject pointer or data commands
// - fast setpoint ramps output to target at 20 mV per microsecond
// - slow setpoint ramps output to target at 5 mV per microsecond
// - power state held in a readable register, updated by power state command
// - applied voltage code held readable, follows the latest accepted setpoint and is loaded from the boot voltage register when output is enabled
// - register read returns whichever register index the master names
// - factory trim command is not offered to users
// - decaying setpoint command is unsupported
// - margin offset pushing setpoint above 1.52 V or below 0 V is not acknowledged
// - readable maker, model, revision and protocol version registers
// - bus errors recorded in a status register, previous read contents kept separately
// - measured output current of both rails is readable
// - fast and slow ramp rates readable from dedicated registers
// - programmed boot voltage register replaces built-in startup setpoint
// - limits for output voltage, output current and temperature held in registers
// - fourteen individual addresses plus two all-call addresses, individual one strapped
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH
`define VSC_CLK_NS      10
`define VSC_STEP_MV     5
`define VSC_FAST_MV_US  20
`define VSC_SLOW_MV_US  5
`define VSC_FAST_CYC    ((`VSC_STEP_MV * 1000) / (`VSC_FAST_MV_US * `VSC_CLK_NS))
`define VSC_SLOW_CYC    ((`VSC_STEP_MV * 1000) / (`VSC_SLOW_MV_US * `VSC_CLK_NS))
`define VSC_IDLE_CYC    64
`define VSC_FRAME_BITS  18
`define VSC_ALLCALL_A   4'hE
`define VSC_ALLCALL_B   4'hF
`define VSC_CMD_FAST    5'h01
`define VSC_CMD_SLOW    5'h02
`define VSC_CMD_DECAY   5'h03
`define VSC_CMD_PS      5'h04
`define VSC_CMD_GET     5'h07
`define VSC_CMD_PTR     5'h08
`define VSC_CMD_DATA    5'h09
`define VSC_CMD_TRIM    5'h1F
`define VSC_IX_MAKER    8'h00
`define VSC_IX_MODEL    8'h01
`define VSC_IX_REV      8'h02
`define VSC_IX_PROTO    8'h05
`define VSC_IX_CAP      8'h06
`define VSC_IX_STAT1    8'h10
`define VSC_IX_STAT2    8'h11
`define VSC_IX_TEMP     8'h12
`define VSC_IX_CUR0     8'h15
`define VSC_IX_CUR1     8'h16
`define VSC_IX_S2PREV   8'h1C
`define VSC_IX_ICCMAX   8'h21
`define VSC_IX_TEMPMAX  8'h22
`define VSC_IX_SRFAST   8'h24
`define VSC_IX_SRSLOW   8'h25
`define VSC_IX_VBOOT    8'h26
`define VSC_IX_VOUTMAX  8'h30
`define VSC_IX_VID      8'h31
`define VSC_IX_PSTATE   8'h32
`define VSC_IX_OFFSET   8'h33
`define VSC_IX_MULTI    8'h34
`define VSC_IX_PTR      8'h35
// identity values are arbitrary
`define VSC_MAKER_ID    8'h5A
`define VSC_MODEL_ID    8'h3C
`define VSC_REV_ID      8'h01
`define VSC_PROTO_ID    8'h01
`define VSC_CAP_DEF     8'h81
`define VSC_VBOOT_DEF   8'h97
`define VSC_VOUTMAX_DEF 8'hFF
`define VSC_ICCMAX_DEF  8'h64
`define VSC_TEMPMAX_DEF 8'h64
`define VSC_CTRL_DEF    8'h01
`define VSC_BE_PARITY   0
`define VSC_BE_UNSUP    1
`define VSC_BE_RANGE    2
`define VSC_CTRL_EN     0
`define VSC_AXI_CTRL    8'h00
`define VSC_AXI_CURR    8'h04
`define VSC_AXI_STAT    8'h08
`define VSC_AXI_BERR    8'h0C
`define VSC_RESP_OKAY   2'h0
`define VSC_RESP_SLVERR 2'h2
`endif

// ===== rtl/vsc_pkg.sv
// types of the serial voltage command decoder
package vsc_pkg;
   typedef enum logic [2:0] {
      LS_IDLE = 3'h0,
      LS_RX   = 3'h1,
      LS_ACK  = 3'h3,
      LS_TX   = 3'h2,
      LS_END  = 3'h6
   } vsc_link_st_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [4:0] cmd;
      logic [7:0] data;
      logic       par;
   } vsc_frame_t;

   typedef struct packed {
      logic [5:0]   sync1;
      logic [5:0]   sync2;
      logic         clk_prev;
      vsc_link_st_t st;
      logic [4:0]   bitcnt;
      logic [16:0]  sh;
      logic [6:0]   idle;
      logic         rd;
      logic [7:0]   txd;
      logic         out;
      logic         oe;
      logic [7:0]   ptr;
      logic [7:0]   vid;
      logic [7:0]   pstate;
      logic [7:0]   offset;
      logic [7:0]   iccmax;
      logic [7:0]   tempmax;
      logic [7:0]   vboot;
      logic [7:0]   voutmax;
      logic [7:0]   multi;
      logic [7:0]   berr;
      logic [7:0]   berr_prev;
      logic [7:0]   dac;
      logic [7:0]   rcnt;
      logic         fast;
      logic         en_prev;
      logic [7:0]   ctrl;
      logic [7:0]   cur0;
      logic [7:0]   cur1;
      logic [7:0]   temp;
      logic [7:0]   awaddr;
      logic         aw_have;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic         w_have;
      logic         awready;
      logic         wready;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         arready;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
   } vsc_state_t;
endpackage

// ===== rtl/vsc_decoder.sv
// serial voltage command decoder with an axi4-lite side port
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vsc_defs.svh"
module vsc_decoder (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        vclk_pin,
   input  wire logic        vdio_in,
   output var  logic        vdio_out,
   output var  logic        vdio_oe,
   input  wire logic [3:0]  addr_strap,
   output var  logic [7:0]  dac_code,
   output var  logic [7:0]  power_state,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output var  logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp
);
   logic [1:0]             rst_sync_q;
   logic                   rst_n;
   vsc_pkg::vsc_state_t    q;
   vsc_pkg::vsc_state_t    d;
   vsc_pkg::vsc_frame_t    fr;
   logic                   rise;
   logic                   fall;
   logic                   fe;
   logic                   own;
   logic                   hit;
   logic                   par_ok;
   logic                   cfg;
   logic                   known;
   logic                   wr_ok;
   logic                   off_ok;
   logic                   take;
   logic [9:0]             sum;
   logic [7:0]             tgt;
   logic                   step;
   logic [7:0]             reload;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // signed margin added to a code; bits 9:8 non-zero means outside 0 V .. 1.52 V
   function automatic logic [9:0] eff(input logic [7:0] v, input logic [7:0] o);
      eff = {2'b00, v} + {{2{o[7]}}, o};
   endfunction

   function automatic logic [7:0] rd_reg(input logic [7:0] ix);
      case (ix)
         `VSC_IX_MAKER:   rd_reg = `VSC_MAKER_ID;
         `VSC_IX_MODEL:   rd_reg = `VSC_MODEL_ID;
         `VSC_IX_REV:     rd_reg = `VSC_REV_ID;
         `VSC_IX_PROTO:   rd_reg = `VSC_PROTO_ID;
         `VSC_IX_CAP:     rd_reg = `VSC_CAP_DEF;
         `VSC_IX_STAT1:   rd_reg = {7'h00, q.dac != tgt};
         `VSC_IX_STAT2:   rd_reg = q.berr;
         `VSC_IX_TEMP:    rd_reg = q.temp;
         `VSC_IX_CUR0:    rd_reg = q.cur0;
         `VSC_IX_CUR1:    rd_reg = q.cur1;
         `VSC_IX_S2PREV:  rd_reg = q.berr_prev;
         `VSC_IX_ICCMAX:  rd_reg = q.iccmax;
         `VSC_IX_TEMPMAX: rd_reg = q.tempmax;
         `VSC_IX_SRFAST:  rd_reg = 8'(`VSC_FAST_MV_US);
         `VSC_IX_SRSLOW:  rd_reg = 8'(`VSC_SLOW_MV_US);
         `VSC_IX_VBOOT:   rd_reg = q.vboot;
         `VSC_IX_VOUTMAX: rd_reg = q.voutmax;
         `VSC_IX_VID:     rd_reg = q.vid;
         `VSC_IX_PSTATE:  rd_reg = q.pstate;
         `VSC_IX_OFFSET:  rd_reg = q.offset;
         `VSC_IX_MULTI:   rd_reg = q.multi;
         `VSC_IX_PTR:     rd_reg = q.ptr;
         default:         rd_reg = 8'h00;
      endcase
   endfunction

   // vclk and vdio pass sync1 then sync2; only sync2 and clk_prev feed logic
   assign rise   = q.sync2[0] & ~q.clk_prev;
   assign fall   = ~q.sync2[0] & q.clk_prev;
   assign fr     = {q.sh, q.sync2[1]};
   assign fe     = rise && (q.st == vsc_pkg::LS_IDLE || q.st == vsc_pkg::LS_RX)
                   && q.bitcnt == 5'(`VSC_FRAME_BITS - 1);
   assign own    = fr.addr == q.sync2[5:2];
   assign hit    = own || fr.addr == `VSC_ALLCALL_A || fr.addr == `VSC_ALLCALL_B;
   assign par_ok = ~^fr;
   assign cfg    = fr.cmd == `VSC_CMD_PTR || fr.cmd == `VSC_CMD_DATA;
   // trim and decaying setpoint fall outside this list and are never acknowledged
   assign known  = fr.cmd == `VSC_CMD_FAST || fr.cmd == `VSC_CMD_SLOW || fr.cmd == `VSC_CMD_PS
                   || fr.cmd == `VSC_CMD_GET || cfg;
   assign wr_ok  = q.ptr == `VSC_IX_ICCMAX || q.ptr == `VSC_IX_TEMPMAX || q.ptr == `VSC_IX_VBOOT
                   || q.ptr == `VSC_IX_VOUTMAX || q.ptr == `VSC_IX_OFFSET || q.ptr == `VSC_IX_MULTI;
   assign off_ok = eff(q.vid, fr.data) < 10'h100;
   assign take   = hit && (par_ok || cfg) && known
                   && !(fr.cmd == `VSC_CMD_GET && !own)
                   && !(fr.cmd == `VSC_CMD_DATA && (!wr_ok || (q.ptr == `VSC_IX_OFFSET && !off_ok)));
   assign sum    = eff(q.vid, q.offset);
   // a later setpoint may push past the margin window; clamp instead of wrapping
   assign tgt    = sum[9] ? 8'h00 : (sum[8] ? 8'hFF : sum[7:0]);
   assign step   = q.ctrl[`VSC_CTRL_EN] && q.dac != tgt && q.rcnt == 8'h00;
   assign reload = q.fast ? 8'(`VSC_FAST_CYC - 1) : 8'(`VSC_SLOW_CYC - 1);

   always_comb begin
      d          = q;
      d.sync1    = {addr_strap, vdio_in, vclk_pin};
      d.sync2    = q.sync1;
      d.clk_prev = q.sync2[0];

      // link framing; a quiet link drops back to idle so framing resyncs
      if (q.st != vsc_pkg::LS_IDLE) begin
         if (rise) begin
            d.idle = 7'h00;
         end else if (q.idle == 7'(`VSC_IDLE_CYC - 1)) begin
            d.st     = vsc_pkg::LS_IDLE;
            d.oe     = 1'b0;
            d.bitcnt = 5'h00;
         end else begin
            d.idle = q.idle + 7'h01;
         end
      end
      unique case (q.st)
         vsc_pkg::LS_IDLE, vsc_pkg::LS_RX: begin
            if (rise) begin
               d.sh     = {q.sh[15:0], q.sync2[1]};
               d.bitcnt = q.bitcnt + 5'h01;
               d.st     = vsc_pkg::LS_RX;
               d.idle   = 7'h00;
            end
         end
         vsc_pkg::LS_ACK: begin
            if (fall) begin
               if (q.bitcnt == 5'h00) begin
                  d.oe     = 1'b1;
                  d.out    = 1'b1;
                  d.bitcnt = 5'h01;
               end else if (q.rd) begin
                  d.out    = q.txd[7];
                  d.bitcnt = 5'h07;
                  d.st     = vsc_pkg::LS_TX;
               end else begin
                  d.oe = 1'b0;
                  d.st = vsc_pkg::LS_END;
               end
            end
         end
         vsc_pkg::LS_TX: begin
            if (fall) begin
               if (q.bitcnt == 5'h00) begin
                  d.oe = 1'b0;
                  d.st = vsc_pkg::LS_END;
               end else begin
                  d.out    = q.txd[3'(q.bitcnt - 5'h01)];
                  d.bitcnt = q.bitcnt - 5'h01;
               end
            end
         end
         vsc_pkg::LS_END: begin
         end
         default: begin
            d.st = vsc_pkg::LS_IDLE;
            d.oe = 1'b0;
         end
      endcase

      // output ramp, one code step per interval; code 0 means off
      d.en_prev = q.ctrl[`VSC_CTRL_EN];
      if (q.ctrl[`VSC_CTRL_EN] && !q.en_prev) begin
         d.vid = q.vboot;
      end
      if (!q.ctrl[`VSC_CTRL_EN]) begin
         d.dac  = 8'h00;
         d.rcnt = reload;
      end else if (q.dac == tgt) begin
         d.rcnt = reload;
      end else if (step) begin
         d.dac  = (q.dac < tgt) ? q.dac + 8'h01 : q.dac - 8'h01;
         d.rcnt = reload;
      end else begin
         d.rcnt = q.rcnt - 8'h01;
      end

      // command execution at the last frame bit
      if (fe) begin
         if (take) begin
            d.st     = vsc_pkg::LS_ACK;
            d.bitcnt = 5'h00;
            d.rd     = fr.cmd == `VSC_CMD_GET;
            unique case (fr.cmd)
               `VSC_CMD_FAST: begin
                  d.vid  = fr.data;
                  d.fast = 1'b1;
                  d.rcnt = 8'(`VSC_FAST_CYC - 1);
               end
               `VSC_CMD_SLOW: begin
                  d.vid  = fr.data;
                  d.fast = 1'b0;
                  d.rcnt = 8'(`VSC_SLOW_CYC - 1);
               end
               `VSC_CMD_PS:  d.pstate = fr.data;
               `VSC_CMD_PTR: d.ptr = fr.data;
               `VSC_CMD_DATA: begin
                  case (q.ptr)
                     `VSC_IX_ICCMAX:  d.iccmax = fr.data;
                     `VSC_IX_TEMPMAX: d.tempmax = fr.data;
                     `VSC_IX_VBOOT:   d.vboot = fr.data;
                     `VSC_IX_VOUTMAX: d.voutmax = fr.data;
                     `VSC_IX_OFFSET:  d.offset = fr.data;
                     `VSC_IX_MULTI:   d.multi = fr.data;
                     default: begin
                     end
                  endcase
               end
               `VSC_CMD_GET: begin
                  d.txd = rd_reg(fr.data);
                  if (fr.data == `VSC_IX_STAT2) begin
                     d.berr_prev = q.berr;
                     d.berr      = 8'h00;
                  end
               end
               default: begin
               end
            endcase
         end else begin
            d.st = vsc_pkg::LS_END;
         end
         // error bits are set after any clear above, so a new error is never lost
         if (hit && !par_ok && !cfg) begin
            d.berr[`VSC_BE_PARITY] = 1'b1;
         end
         if (hit && !known) begin
            d.berr[`VSC_BE_UNSUP] = 1'b1;
         end
         if (hit && fr.cmd == `VSC_CMD_DATA && q.ptr == `VSC_IX_OFFSET && !off_ok) begin
            d.berr[`VSC_BE_RANGE] = 1'b1;
         end
      end

      // axi4-lite slave, one write and one read outstanding
      if (s_axi_awvalid && q.awready) begin
         d.awaddr  = s_axi_awaddr;
         d.aw_have = 1'b1;
      end
      if (s_axi_wvalid && q.wready) begin
         d.wdata  = s_axi_wdata;
         d.wstrb  = s_axi_wstrb;
         d.w_have = 1'b1;
      end
      if (q.aw_have && q.w_have && !q.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = `VSC_RESP_OKAY;
         case (q.awaddr)
            `VSC_AXI_CTRL: begin
               if (q.wstrb[0]) d.ctrl = q.wdata[7:0];
            end
            `VSC_AXI_CURR: begin
               if (q.wstrb[0]) d.cur0 = q.wdata[7:0];
               if (q.wstrb[1]) d.cur1 = q.wdata[15:8];
               if (q.wstrb[2]) d.temp = q.wdata[23:16];
            end
            `VSC_AXI_STAT, `VSC_AXI_BERR: begin
            end
            default: d.bresp = `VSC_RESP_SLVERR;
         endcase
      end else if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      d.awready = !d.aw_have && !d.bvalid;
      d.wready  = !d.w_have && !d.bvalid;

      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp  = `VSC_RESP_OKAY;
         case (s_axi_araddr)
            `VSC_AXI_CTRL: d.rdata = {24'h000000, q.ctrl};
            `VSC_AXI_CURR: d.rdata = {8'h00, q.temp, q.cur1, q.cur0};
            `VSC_AXI_STAT: d.rdata = {q.pstate, q.dac, q.vid, 5'h00, q.st};
            `VSC_AXI_BERR: d.rdata = {16'h0000, q.berr_prev, q.berr};
            default: begin
               d.rdata = 32'h00000000;
               d.rresp = `VSC_RESP_SLVERR;
            end
         endcase
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      d.arready = !d.rvalid;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q         <= '0;
         q.vboot   <= `VSC_VBOOT_DEF;
         q.voutmax <= `VSC_VOUTMAX_DEF;
         q.iccmax  <= `VSC_ICCMAX_DEF;
         q.tempmax <= `VSC_TEMPMAX_DEF;
         q.ctrl    <= `VSC_CTRL_DEF;
      end else begin
         q <= d;
      end
   end

   assign vdio_out      = q.out;
   assign vdio_oe       = q.oe;
   assign dac_code      = q.dac;
   assign power_state   = q.pstate;
   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

   // cycles since the last ramp step, saturating
   logic [7:0] gap_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q <= 8'hFF;
      end else if (step) begin
         gap_q <= 8'h01;
      end else if (gap_q != 8'hFF) begin
         gap_q <= gap_q + 8'h01;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   ack_drive_a: assert property ($rose(q.oe) |-> q.st == vsc_pkg::LS_ACK && q.out)
      else $error("link driven outside the acknowledge slot");
   cfg_parity_a: assert property (fe && own && !par_ok && fr.cmd == `VSC_CMD_PTR |=>
      q.st == vsc_pkg::LS_ACK && q.ptr == $past(fr.data))
      else $error("pointer command lost on parity");
   trim_nak_a: assert property (fe && fr.cmd == `VSC_CMD_TRIM |=> q.st == vsc_pkg::LS_END)
      else $error("trim command acknowledged");
   decay_nak_a: assert property (fe && fr.cmd == `VSC_CMD_DECAY |=> q.st != vsc_pkg::LS_ACK)
      else $error("decaying setpoint acknowledged");
   fast_rate_a: assert property (step && q.fast |-> gap_q >= 8'(`VSC_FAST_CYC))
      else $error("fast ramp stepped too soon");
   slow_rate_a: assert property (step && !q.fast |-> gap_q >= 8'(`VSC_SLOW_CYC))
      else $error("slow ramp stepped too soon");
   offset_range_a: assert property (fe && own && fr.cmd == `VSC_CMD_DATA && q.ptr == `VSC_IX_OFFSET
      && !off_ok |=> q.st == vsc_pkg::LS_END && $stable(q.offset))
      else $error("out of range margin accepted");
   vid_track_a: assert property (fe && own && par_ok && fr.cmd == `VSC_CMD_SLOW |=>
      q.vid == $past(fr.data) && !q.fast)
      else $error("setpoint not applied");
   pstate_set_a: assert property (fe && own && par_ok && fr.cmd == `VSC_CMD_PS |=>
      power_state == $past(fr.data))
      else $error("power state not applied");
   read_first_a: assert property (q.st == vsc_pkg::LS_TX && $past(q.st) == vsc_pkg::LS_ACK |->
      q.out == q.txd[7] && q.oe)
      else $error("read data not on the link");

   fast_cmd_c: cover property (fe && take && fr.cmd == `VSC_CMD_FAST);
   read_cmd_c: cover property (q.st == vsc_pkg::LS_TX ##1 q.st == vsc_pkg::LS_END);
   cfg_write_c: cover property (fe && take && fr.cmd == `VSC_CMD_DATA);
   ramp_step_c: cover property (step && q.fast);
endmodule // vsc_decoder
`default_nettype wire

// ===== tb/vsc_master.sv
// behavioural voltage bus master driving the link side
`timescale 1ns/1ps
`default_nettype none
module vsc_master (
   input  wire logic ref_clk,
   input  wire logic dev_oe,
   input  wire logic dev_out,
   output var  logic vclk,
   output wire logic vdio
);
   logic m_en;
   logic m_bit;
   // released wire reads the pull-up level
   assign vdio = dev_oe ? dev_out : (m_en ? m_bit : 1'b1);
   initial begin
      vclk = 1'b0;
      m_en = 1'b0;
      m_bit = 1'b0;
   end
   task automatic half;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic frame(input logic [3:0] a, input logic [4:0] c, input logic [7:0] d, input logic bad,
                        output logic ack, output logic [7:0] rd);
      logic [17:0] f;
      int          i;
      begin
         f = {a, c, d, ^{a, c, d} ^ bad};
         for (i = 17; i >= 0; i--) begin
            vclk <= 1'b0;
            m_en <= 1'b1;
            m_bit <= f[i];
            half;
            vclk <= 1'b1;
            half;
         end
         vclk <= 1'b0;
         m_en <= 1'b0;
         half;
         vclk <= 1'b1;
         ack = dev_oe & vdio;
         half;
         rd = 8'h00;
         if (c == 5'h07) begin
            for (i = 7; i >= 0; i--) begin
               vclk <= 1'b0;
               half;
               vclk <= 1'b1;
               rd[i] = vdio;
               half;
            end
         end
         vclk <= 1'b0;
         // clock stands still well past the 64-cycle idle gap
         repeat (100) @(posedge ref_clk);
      end
   endtask
endmodule // vsc_master
`default_nettype wire

// ===== tb/vsc_decoder_tb_top.sv
// self-checking bench of the voltage command decoder
`timescale 1ns/1ps
`default_nettype none
module vsc_decoder_tb_top;
   localparam logic [3:0] ME = 4'h3;
   logic        ref_clk, reset_n, vclk, vdio_out, vdio_oe, ack;
   wire logic   vdio;
   logic [7:0]  dac_code, power_state, aa, ara, rd;
   logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic [31:0] wd, rdt, d;
   logic [3:0]  ws, strap;
   logic [1:0]  bp, rp;
   logic [15:0] n;
   int          err_count, checks;
   vsc_decoder u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .vclk_pin(vclk), .vdio_in(vdio),
      .vdio_out(vdio_out), .vdio_oe(vdio_oe), .addr_strap(strap), .dac_code(dac_code), .power_state(power_state),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(aa), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bp),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .s_axi_rdata(rdt), .s_axi_rresp(rp));
   vsc_master u_mst (.ref_clk(ref_clk), .dev_oe(vdio_oe), .dev_out(vdio_out), .vclk(vclk), .vdio(vdio));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      begin
         awv <= 1'b1;
         wv <= 1'b1;
         aa <= a;
         wd <= v;
         ws <= 4'hF;
         br <= 1'b1;
         // only the watchdog ends a wait for the answer
         while (bv !== 1'b1) begin
            @(posedge ref_clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
         end
         chk({30'h0, bp}, {30'h0, r});
         br <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [1:0] r);
      begin
         arv <= 1'b1;
         ara <= a;
         rr <= 1'b1;
         while (rv !== 1'b1) begin
            @(posedge ref_clk);
            if (arr === 1'b1) arv <= 1'b0;
         end
         d = rdt;
         chk({30'h0, rp}, {30'h0, r});
         rr <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task automatic lk(input logic [3:0] a, input logic [4:0] c, input logic [7:0] v, input logic bad);
      u_mst.frame(a, c, v, bad, ack, rd);
   endtask
   // cycles between the second and third code step, so a half-done step never skews it
   task automatic gap;
      logic [7:0] p;
      int         c;
      begin
         p = dac_code;
         c = 0;
         n = 0;
         while (c < 3 && n < 3000) begin
            @(posedge ref_clk);
            n++;
            if (dac_code !== p) begin
               p = dac_code;
               c++;
               if (c == 2) n = 0;
            end
         end
      end
   endtask
   task automatic t_ident;
      logic [7:0] ix [8] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h24, 8'h25, 8'h26, 8'h21};
      logic [7:0] ex [8] = '{8'h5A, 8'h3C, 8'h01, 8'h01, 8'h14, 8'h05, 8'h97, 8'h64};
      for (int i = 0; i < 8; i++) begin
         lk(ME, 5'h07, ix[i], 1'b0);
         chk({31'h0, ack}, 32'h1);
         chk({24'h0, rd}, {24'h0, ex[i]});
      end
      $display("test ident done");
   endtask
   task automatic t_vid;
      int t;
      begin
         lk(ME, 5'h01, 8'h9A, 1'b0);
         chk({31'h0, ack}, 32'h1);
         gap;
         chk({16'h0, n}, 32'd25);
         t = 0;
         while (t < 6000 && dac_code !== 8'h9A) begin
            @(posedge ref_clk);
            t++;
         end
         chk({24'h0, dac_code}, 32'h9A);
         lk(ME, 5'h07, 8'h31, 1'b0);
         chk({24'h0, rd}, 32'h9A);
         lk(ME, 5'h02, 8'h96, 1'b0);
         gap;
         chk({16'h0, n}, 32'd100);
         $display("test setpoint done");
      end
   endtask
   task automatic t_ps;
      lk(ME, 5'h04, 8'h02, 1'b0);
      chk({31'h0, ack}, 32'h1);
      chk({24'h0, power_state}, 32'h02);
      axi_rd(8'h08, 2'h0);
      chk(d, 32'h02969600);
      $display("test power state done");
   endtask
   task automatic t_ptr;
      lk(ME, 5'h08, 8'h21, 1'b1);
      chk({31'h0, ack}, 32'h1);
      lk(ME, 5'h09, 8'h55, 1'b1);
      chk({31'h0, ack}, 32'h1);
      lk(ME, 5'h07, 8'h21, 1'b0);
      chk({24'h0, rd}, 32'h55);
      lk(ME, 5'h08, 8'h26, 1'b0);
      lk(ME, 5'h09, 8'h80, 1'b0);
      axi_wr(8'h00, 32'h00000000, 2'h0);
      axi_wr(8'h00, 32'h00000001, 2'h0);
      lk(ME, 5'h07, 8'h31, 1'b0);
      chk({24'h0, rd}, 32'h80);
      $display("test pointer done");
   endtask
   task automatic t_bad;
      lk(ME, 5'h1F, 8'h00, 1'b0);
      chk({31'h0, ack}, 32'h0);
      lk(ME, 5'h03, 8'h90, 1'b0);
      chk({31'h0, ack}, 32'h0);
      lk(4'h5, 5'h01, 8'h90, 1'b0);
      chk({31'h0, ack}, 32'h0);
      strap <= 4'h5;
      lk(4'h5, 5'h04, 8'h02, 1'b0);
      chk({31'h0, ack}, 32'h1);
      strap <= ME;
      lk(4'hE, 5'h02, 8'h96, 1'b0);
      chk({31'h0, ack}, 32'h1);
      axi_rd(8'h0C, 2'h0);
      chk(d, 32'h00000002);
      lk(ME, 5'h07, 8'h11, 1'b0);
      chk({24'h0, rd}, 32'h02);
      lk(ME, 5'h07, 8'h1C, 1'b0);
      chk({24'h0, rd}, 32'h02);
      axi_rd(8'h0C, 2'h0);
      chk(d, 32'h00000200);
      $display("test refusals done");
   endtask
   task automatic t_margin;
      lk(ME, 5'h08, 8'h33, 1'b0);
      lk(ME, 5'h09, 8'h70, 1'b0);
      chk({31'h0, ack}, 32'h0);
      axi_rd(8'h0C, 2'h0);
      chk(d, 32'h00000204);
      $display("test margin done");
   endtask
   task automatic t_axi;
      axi_rd(8'h00, 2'h0);
      chk(d, 32'h00000001);
      axi_wr(8'h04, 32'h00030201, 2'h0);
      axi_rd(8'h04, 2'h0);
      chk(d, 32'h00030201);
      lk(ME, 5'h07, 8'h16, 1'b0);
      chk({24'h0, rd}, 32'h02);
      axi_wr(8'h10, 32'h0000FFFF, 2'h2);
      axi_rd(8'h10, 2'h2);
      chk(d, 32'h0);
      axi_wr(8'h0C, 32'h0000FFFF, 2'h0);
      axi_rd(8'h0C, 2'h0);
      chk(d, 32'h00000204);
      $display("test register bus done");
   endtask
   initial begin
      reset_n = 1'b0;
      {awv, wv, br, arv, rr} = 5'h00;
      {aa, ara, ws, wd} = '0;
      strap = ME;
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      t_ident;
      t_vid;
      t_ps;
      t_ptr;
      t_bad;
      t_margin;
      t_axi;
      end_sim;
   end
   // about 30 frames of some 400 to 530 cycles each plus ramps fit well inside this span
   initial begin
      #400000;
      err_count++;
      end_sim;
   end
endmodule // vsc_decoder_tb_top
`default_nettype wire
